// ===== src/tqa_pkg.sv
// Purpose: Shared constants and types of the trigger qualify / average sequencer.
// Assumes: APB slave, 32-bit data, one word per register; times held as pclk cycle counts.
// Notes: Operation summary follows.
package tqa_pkg;

  // Register byte offsets
  localparam logic [7:0] TQA_OFS_CTRL = 8'h00;
  localparam logic [7:0] TQA_OFS_CMD = 8'h04;
  localparam logic [7:0] TQA_OFS_AVG_CNT = 8'h08;
  localparam logic [7:0] TQA_OFS_TRACE_CNT = 8'h0C;
  localparam logic [7:0] TQA_OFS_TRIG_CNT = 8'h10;
  localparam logic [7:0] TQA_OFS_LEVEL = 8'h14;
  localparam logic [7:0] TQA_OFS_HYST = 8'h18;
  localparam logic [7:0] TQA_OFS_DROPOUT = 8'h1C;
  localparam logic [7:0] TQA_OFS_HOLDOFF = 8'h20;
  localparam logic [7:0] TQA_OFS_APERTURE = 8'h24;
  localparam logic [7:0] TQA_OFS_TRACE_TIME = 8'h28;
  localparam logic [7:0] TQA_OFS_STATUS = 8'h2C;
  localparam logic [7:0] TQA_OFS_RESULT = 8'h30;
  localparam logic [7:0] TQA_OFS_RESULT_HI = 8'h34;

  // Field positions
  localparam int TQA_CTRL_CONT_BIT = 0;
  localparam int TQA_CTRL_TRACE_BIT = 1;
  localparam int TQA_CTRL_AVG_MOV_BIT = 2;
  localparam int TQA_CTRL_TRACE_MOV_BIT = 3;
  localparam int TQA_CTRL_TRIG_IMM_BIT = 4;
  localparam int TQA_CMD_INIT_BIT = 0;
  localparam int TQA_CMD_ABORT_BIT = 1;

  // Reset values
  localparam logic [4:0] TQA_RST_AVG_CNT = 5'h04;
  localparam logic [4:0] TQA_RST_TRACE_CNT = 5'h02;
  localparam logic [15:0] TQA_RST_TRIG_CNT = 16'h0001;
  localparam logic [15:0] TQA_RST_LEVEL = 16'h1000;
  localparam logic [15:0] TQA_RST_HYST = 16'h0100;
  localparam logic [23:0] TQA_RST_DROPOUT = 24'h000000;
  localparam logic [23:0] TQA_RST_HOLDOFF = 24'h000000;
  localparam logic [23:0] TQA_RST_APERTURE = 24'h000064;
  localparam logic [23:0] TQA_RST_TRACE_TIME = 24'h000064;

  // Averaging filter depth, also the largest average count
  localparam logic [4:0] TQA_FILT_DEPTH = 5'h10;

  typedef enum logic [4:0] {
    TQA_ST_IDLE = 5'h01,
    TQA_ST_WAIT = 5'h02,
    TQA_ST_NONINV = 5'h04,
    TQA_ST_WAIT_INV = 5'h08,
    TQA_ST_INV = 5'h10
  } tqa_state_type;

  typedef struct packed {
    logic cont;
    logic trace;
    logic avg_moving;
    logic trace_moving;
    logic trig_imm;
    logic [4:0] avg_cnt;
    logic [4:0] trace_cnt;
    logic [15:0] trig_count;
    logic [15:0] level;
    logic [15:0] hyst;
    logic [23:0] dropout;
    logic [23:0] holdoff;
    logic [23:0] aperture;
    logic [23:0] trace_time;
  } tqa_cfg_type;

  typedef struct packed {
    logic [35:0] sum;
    logic [4:0] count;
    logic settled;
  } tqa_result_type;

endpackage

// ===== src/tqa_sequencer.sv
// Purpose: Trigger qualification, chopped phase sequencing and averaging of a power sensor channel.
// Assumes: power_sample is synchronous to pclk; one sample per power_valid.
// Notes: Results are window sums; software divides by the result count.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tqa_sequencer
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Detector samples
  input wire logic [15:0] power_sample,
  input wire logic power_valid,
  // Measurement outputs
  output logic trig_sync,
  output logic result_valid,
  output tqa_pkg::tqa_result_type result
);
  import tqa_pkg::*;

  typedef struct packed {
    tqa_cfg_type cfg;
    tqa_state_type state;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic above;
    logic [23:0] drop_cnt;
    logic [23:0] hold_cnt;
    logic [23:0] tmr;
    logic [31:0] acc;
    logic [15:0][31:0] filt;
    logic [3:0] wr_idx;
    logic [4:0] fill;
    logic [35:0] win_sum;
    logic [4:0] meas_cnt;
    logic [15:0] trig_cnt;
    logic result_new;
    logic sync;
    logic res_valid;
    tqa_result_type res;
  } tqa_regs_type;

  tqa_regs_type r;
  tqa_regs_type n;
  logic setup;
  logic access;
  logic [15:0] low_thr;
  logic crossing;
  logic rising;
  logic armed;
  logic trig_evt;
  logic [4:0] eff_cnt;
  logic moving;
  logic [23:0] phase_len;
  logic [31:0] acc_nxt;
  logic [31:0] oldest;
  logic [35:0] sum_nxt;
  logic [4:0] fill_nxt;
  logic [4:0] mcnt;
  logic [15:0] tcnt_nxt;
  logic end_cycle;
  logic start;
  logic abort;

  always_comb
  begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.res_valid = 1'b0;
    setup = psel & ~penable;
    access = psel & penable & r.pready;
    start = 1'b0;
    abort = 1'b0;
    end_cycle = 1'b0;
    acc_nxt = r.acc;
    oldest = 32'h00000000;
    sum_nxt = r.win_sum;
    fill_nxt = r.fill;
    mcnt = r.meas_cnt;
    tcnt_nxt = r.trig_cnt;

    // Bus: read data captured in setup, so pready and prdata leave flops together
    if (setup)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h00000000;
      case (paddr[7:0])
        TQA_OFS_CTRL: n.prdata[4:0] = {r.cfg.trig_imm, r.cfg.trace_moving, r.cfg.avg_moving,
                                        r.cfg.trace, r.cfg.cont};
        TQA_OFS_CMD: n.prdata = 32'h00000000;
        TQA_OFS_AVG_CNT: n.prdata[4:0] = r.cfg.avg_cnt;
        TQA_OFS_TRACE_CNT: n.prdata[4:0] = r.cfg.trace_cnt;
        TQA_OFS_TRIG_CNT: n.prdata[15:0] = r.cfg.trig_count;
        TQA_OFS_LEVEL: n.prdata[15:0] = r.cfg.level;
        TQA_OFS_HYST: n.prdata[15:0] = r.cfg.hyst;
        TQA_OFS_DROPOUT: n.prdata[23:0] = r.cfg.dropout;
        TQA_OFS_HOLDOFF: n.prdata[23:0] = r.cfg.holdoff;
        TQA_OFS_APERTURE: n.prdata[23:0] = r.cfg.aperture;
        TQA_OFS_TRACE_TIME: n.prdata[23:0] = r.cfg.trace_time;
        TQA_OFS_STATUS: n.prdata = {r.trig_cnt, r.meas_cnt, r.res.settled, r.result_new,
                                    r.sync, r.above, r.state, 2'h0};
        TQA_OFS_RESULT: n.prdata = r.res.sum[31:0];
        TQA_OFS_RESULT_HI: n.prdata = {23'h000000, r.res.count, r.res.sum[35:32]};
        default:
        begin
          n.pslverr = 1'b1;
        end
      endcase
      if (paddr[1:0] != 2'h0)
      begin
        n.pslverr = 1'b1;
        n.prdata = 32'h00000000;
      end
    end

    if (access && !r.pslverr)
    begin
      if (pwrite)
      begin
        case (paddr[7:0])
          TQA_OFS_CTRL:
          begin
            n.cfg.cont = pwdata[TQA_CTRL_CONT_BIT];
            n.cfg.trace = pwdata[TQA_CTRL_TRACE_BIT];
            n.cfg.avg_moving = pwdata[TQA_CTRL_AVG_MOV_BIT];
            n.cfg.trace_moving = pwdata[TQA_CTRL_TRACE_MOV_BIT];
            n.cfg.trig_imm = pwdata[TQA_CTRL_TRIG_IMM_BIT];
          end
          TQA_OFS_CMD:
          begin
            start = pwdata[TQA_CMD_INIT_BIT];
            abort = pwdata[TQA_CMD_ABORT_BIT];
          end
          TQA_OFS_AVG_CNT: n.cfg.avg_cnt = pwdata[4:0];
          TQA_OFS_TRACE_CNT: n.cfg.trace_cnt = pwdata[4:0];
          TQA_OFS_TRIG_CNT: n.cfg.trig_count = pwdata[15:0];
          TQA_OFS_LEVEL: n.cfg.level = pwdata[15:0];
          TQA_OFS_HYST: n.cfg.hyst = pwdata[15:0];
          TQA_OFS_DROPOUT: n.cfg.dropout = pwdata[23:0];
          TQA_OFS_HOLDOFF: n.cfg.holdoff = pwdata[23:0];
          TQA_OFS_APERTURE: n.cfg.aperture = pwdata[23:0];
          TQA_OFS_TRACE_TIME: n.cfg.trace_time = pwdata[23:0];
          default:
          begin
          end
        endcase
      end
      else if (paddr[7:0] == TQA_OFS_RESULT)
      begin
        n.result_new = 1'b0;
      end
    end

    // Threshold with hysteresis; below level minus hysteresis is the inactive side
    low_thr = (r.cfg.level > r.cfg.hyst) ? (r.cfg.level - r.cfg.hyst) : 16'h0000;
    crossing = 1'b0;
    if (power_valid)
    begin
      if (!r.above && power_sample >= r.cfg.level)
      begin
        crossing = 1'b1;
      end
      else if (r.above && power_sample < low_thr)
      begin
        crossing = 1'b1;
      end
    end
    rising = crossing & ~r.above;
    if (crossing)
    begin
      n.above = ~r.above;
    end

    // Dropout restarts on every crossing, so short gaps between slots never arm
    armed = (r.drop_cnt >= r.cfg.dropout);
    if (crossing)
    begin
      n.drop_cnt = 24'h000000;
    end
    else if (!r.above && r.drop_cnt != 24'hFFFFFF)
    begin
      n.drop_cnt = r.drop_cnt + 24'h000001;
    end

    if (r.hold_cnt != 24'h000000)
    begin
      n.hold_cnt = r.hold_cnt - 24'h000001;
    end
    trig_evt = (r.cfg.trig_imm | (rising & armed)) & (r.hold_cnt == 24'h000000);

    // Effective count, clamped to the filter depth
    eff_cnt = r.cfg.trace ? r.cfg.trace_cnt : r.cfg.avg_cnt;
    if (eff_cnt == 5'h00)
    begin
      eff_cnt = 5'h01;
    end
    else if (eff_cnt > TQA_FILT_DEPTH)
    begin
      eff_cnt = TQA_FILT_DEPTH;
    end
    moving = r.cfg.trace ? r.cfg.trace_moving : r.cfg.avg_moving;
    phase_len = r.cfg.trace ? r.cfg.trace_time : r.cfg.aperture;
    if (phase_len == 24'h000000)
    begin
      phase_len = 24'h000001;
    end

    if ((r.state == TQA_ST_NONINV || r.state == TQA_ST_INV) && power_valid)
    begin
      acc_nxt = r.acc + {16'h0000, power_sample};
    end

    case (r.state)
      TQA_ST_IDLE:
      begin
        if (start)
        begin
          n.state = TQA_ST_WAIT;
          n.filt = '0;
          n.wr_idx = 4'h0;
          n.fill = 5'h00;
          n.win_sum = 36'h000000000;
          n.meas_cnt = 5'h00;
          n.trig_cnt = 16'h0000;
          n.res.settled = 1'b0;
        end
      end
      TQA_ST_WAIT:
      begin
        if (trig_evt)
        begin
          n.state = TQA_ST_NONINV;
          n.hold_cnt = r.cfg.holdoff;
          n.trig_cnt = r.trig_cnt + 16'h0001;
          n.tmr = phase_len - 24'h000001;
          acc_nxt = 32'h00000000;
        end
      end
      TQA_ST_NONINV:
      begin
        if (r.tmr != 24'h000000)
        begin
          n.tmr = r.tmr - 24'h000001;
        end
        else if (eff_cnt == 5'h01)
        begin
          // Single noninverted phase, no chopping
          n.res = '{sum: {4'h0, acc_nxt}, count: 5'h01, settled: 1'b1};
          n.res_valid = 1'b1;
          n.result_new = 1'b1;
          n.state = TQA_ST_IDLE;
        end
        else if (r.cfg.trace)
        begin
          n.state = TQA_ST_WAIT_INV;
        end
        else
        begin
          n.state = TQA_ST_INV;
          n.tmr = phase_len - 24'h000001;
        end
      end
      TQA_ST_WAIT_INV:
      begin
        if (trig_evt)
        begin
          n.state = TQA_ST_INV;
          n.hold_cnt = r.cfg.holdoff;
          n.tmr = phase_len - 24'h000001;
        end
      end
      TQA_ST_INV:
      begin
        if (r.tmr != 24'h000000)
        begin
          n.tmr = r.tmr - 24'h000001;
        end
        else
        begin
          // Measurement done: push into ring, drop the oldest once the window is full
          oldest = r.filt[r.wr_idx - eff_cnt[3:0]];
          n.filt[r.wr_idx] = acc_nxt;
          n.wr_idx = r.wr_idx + 4'h1;
          if (r.fill < eff_cnt)
          begin
            fill_nxt = r.fill + 5'h01;
            sum_nxt = r.win_sum + {4'h0, acc_nxt};
          end
          else
          begin
            sum_nxt = r.win_sum + {4'h0, acc_nxt} - {4'h0, oldest};
          end
          n.fill = fill_nxt;
          n.win_sum = sum_nxt;
          mcnt = (r.meas_cnt == 5'h1F) ? r.meas_cnt : r.meas_cnt + 5'h01;
          n.meas_cnt = mcnt;
          if (moving)
          begin
            n.res = '{sum: sum_nxt, count: fill_nxt, settled: (fill_nxt >= eff_cnt)};
            n.res_valid = 1'b1;
            n.result_new = 1'b1;
            end_cycle = 1'b1;
          end
          else if (fill_nxt >= eff_cnt)
          begin
            n.res = '{sum: sum_nxt, count: fill_nxt, settled: 1'b1};
            n.res_valid = 1'b1;
            n.result_new = 1'b1;
            end_cycle = 1'b1;
          end
          else if (r.cfg.trace)
          begin
            n.state = TQA_ST_WAIT;
          end
          else
          begin
            // Next measurement runs without a trigger, sync stays high
            n.state = TQA_ST_NONINV;
            n.tmr = phase_len - 24'h000001;
            acc_nxt = 32'h00000000;
          end
        end
      end
      default:
      begin
        n.state = TQA_ST_IDLE;
      end
    endcase

    if (end_cycle)
    begin
      tcnt_nxt = r.trig_cnt;
      if (!r.cfg.cont || (r.cfg.trig_count != 16'h0000 && tcnt_nxt >= r.cfg.trig_count))
      begin
        n.state = TQA_ST_IDLE;
      end
      else
      begin
        n.state = TQA_ST_WAIT;
      end
      if (!moving)
      begin
        // Repeating: each cycle refills the filter from empty
        n.fill = 5'h00;
        n.win_sum = 36'h000000000;
        n.meas_cnt = 5'h00;
      end
    end

    if (abort)
    begin
      n.state = TQA_ST_IDLE;
    end
    n.acc = acc_nxt;
    n.sync = (n.state == TQA_ST_NONINV) || (n.state == TQA_ST_INV);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.state <= TQA_ST_IDLE;
      r.cfg.avg_cnt <= TQA_RST_AVG_CNT;
      r.cfg.trace_cnt <= TQA_RST_TRACE_CNT;
      r.cfg.trig_count <= TQA_RST_TRIG_CNT;
      r.cfg.level <= TQA_RST_LEVEL;
      r.cfg.hyst <= TQA_RST_HYST;
      r.cfg.dropout <= TQA_RST_DROPOUT;
      r.cfg.holdoff <= TQA_RST_HOLDOFF;
      r.cfg.aperture <= TQA_RST_APERTURE;
      r.cfg.trace_time <= TQA_RST_TRACE_TIME;
    end
    else
    begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign trig_sync = r.sync;
  assign result_valid = r.res_valid;
  assign result = r.res;

endmodule // tqa_sequencer
`default_nettype wire

// ===== test/tqa_sequencer_properties.sv
// Purpose: Port assertions of the trigger qualify / average sequencer.
// Assumes: Zero-wait APB slave, one clock domain.
// Notes: Bound to every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module tqa_sequencer_checker
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Measurement
  input wire logic trig_sync,
  input wire logic result_valid,
  input wire tqa_pkg::tqa_result_type result
);
  import tqa_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  zero_wait_a: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in first access cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access cycle");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_rdata_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // Result closes a phase: sync has just dropped
  result_end_a: assert property (result_valid |-> !trig_sync && $past(trig_sync))
    else $error("result not at end of phase");
  result_pulse_a: assert property (result_valid |=> !result_valid)
    else $error("result strobe longer than one cycle");
  result_count_a: assert property (result_valid |-> result.count inside {[5'h01:5'h10]})
    else $error("result count out of range");
endmodule // tqa_sequencer_checker

bind tqa_sequencer tqa_sequencer_checker i_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trig_sync(trig_sync), .result_valid(result_valid), .result(result)
);
`default_nettype wire

// ===== test/tqa_power_source.sv
// Purpose: Detector sample source in front of the sequencer.
// Assumes: One sample every clock outside reset.
// Notes: Levels are low, inside hysteresis, above trigger level.
`timescale 1ns/1ps
`default_nettype none
module tqa_power_source
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level request
  input wire logic [1:0] lvl_sel,
  // Detector samples
  output logic [15:0] power_sample,
  output logic power_valid
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_valid <= 1'b0;
      power_sample <= 16'h0000;
    end
    else
    begin
      power_valid <= 1'b1;
      case (lvl_sel)
        2'h0: power_sample <= 16'h0000;
        // Below level but not below level minus hysteresis
        2'h1: power_sample <= 16'h0F80;
        default: power_sample <= 16'h2000;
      endcase
    end
  end
endmodule // tqa_power_source
`default_nettype wire

// ===== test/tqa_sequencer_tb.sv
// Purpose: Self-checking bench of the sequencer.
// Assumes: Sample source high unless a test moves it; aperture 4, trace time 3.
// Notes: Expected sums are the sample value times the sampled cycles.
`timescale 1ns/1ps
`default_nettype none
module tqa_sequencer_tb;
  import tqa_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] cnt;
    logic [15:0] trg;
    logic [7:0] hi;
    logic [3:0] rise;
    logic [3:0] res;
    logic [3:0] stl;
    logic [4:0] c;
    logic [35:0] sum;
  } tqa_case_type;
  tqa_case_type tbl [8] = '{
    '{8'h10, 5'h01, 16'h0001, 8'h04, 4'h1, 4'h1, 4'h1, 5'h01, 36'h8000},
    '{8'h14, 5'h01, 16'h0001, 8'h04, 4'h1, 4'h1, 4'h1, 5'h01, 36'h8000},
    '{8'h10, 5'h04, 16'h0001, 8'h20, 4'h1, 4'h1, 4'h1, 5'h04, 36'h40000},
    '{8'h15, 5'h02, 16'h0003, 8'h18, 4'h3, 4'h3, 4'h2, 5'h02, 36'h20000},
    '{8'h15, 5'h02, 16'h0001, 8'h08, 4'h1, 4'h1, 4'h0, 5'h01, 36'h10000},
    '{8'h16, 5'h02, 16'h0000, 8'h0C, 4'h4, 4'h1, 4'h1, 5'h02, 36'h18000},
    '{8'h1B, 5'h02, 16'h0002, 8'h0C, 4'h4, 4'h2, 4'h1, 5'h02, 36'h18000},
    '{8'h1A, 5'h01, 16'h0001, 8'h03, 4'h1, 4'h1, 4'h1, 5'h01, 36'h6000}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] power_sample;
  logic power_valid;
  logic trig_sync;
  logic result_valid;
  tqa_result_type result;
  tqa_result_type last;
  logic [1:0] lvl_sel = 2'h2;
  logic [31:0] q;
  logic err_seen;
  logic sync_d = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  int n_hi = 0, n_rise = 0, n_res = 0, n_stl = 0, cyc = 0, t_first = 0, t_last = 0;

  always #25 pclk = ~pclk;

  tqa_sequencer i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_sample(power_sample), .power_valid(power_valid),
    .trig_sync(trig_sync), .result_valid(result_valid), .result(result)
  );

  tqa_power_source i_src
  (
    .pclk(pclk), .presetn(presetn), .lvl_sel(lvl_sel),
    .power_sample(power_sample), .power_valid(power_valid)
  );

  // Sees the values settled before each edge
  always @(posedge pclk)
  begin
    cyc++;
    if (trig_sync)
      n_hi++;
    if (trig_sync && !sync_d)
    begin
      if (n_rise == 0)
        t_first = cyc;
      t_last = cyc;
      n_rise++;
    end
    if (result_valid)
    begin
      n_res++;
      last = result;
      if (result.settled)
        n_stl++;
    end
    sync_d = trig_sync;
  end

  task automatic stop_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    // A slave that never answers counts as a mismatch
    if (pready !== 1'b1)
      errors++;
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, TQA_OFS_STATUS, 32'h0);
      n++;
    end
    while (q[6:2] !== 5'h01 && n < 400);
    check(q[6:2], 5'h01);
  endtask

  task automatic run(input logic [7:0] ctrl, input logic [4:0] cnt, input logic [15:0] trg);
    apb(1'b1, TQA_OFS_CTRL, {24'h0, ctrl});
    apb(1'b1, TQA_OFS_AVG_CNT, {27'h0, cnt});
    apb(1'b1, TQA_OFS_TRACE_CNT, {27'h0, cnt});
    apb(1'b1, TQA_OFS_TRIG_CNT, {16'h0, trg});
    n_hi = 0;
    n_rise = 0;
    n_res = 0;
    n_stl = 0;
    apb(1'b1, TQA_OFS_CMD, 32'h1);
  endtask

  initial
  begin
    #(30000 * 50);
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TQA_OFS_STATUS, 32'h0);
    check({q[8], q[6:2]}, 6'h01);
    rd_chk(TQA_OFS_AVG_CNT, 32'h4);
    rd_chk(TQA_OFS_TRACE_CNT, 32'h2);
    rd_chk(TQA_OFS_HYST, 32'h100);
    rd_chk(TQA_OFS_APERTURE, 32'h64);
    apb(1'b0, 8'h38, 32'h0);
    check({err_seen, q}, 33'h100000000);
    apb(1'b1, TQA_OFS_APERTURE, 32'h4);
    apb(1'b1, TQA_OFS_TRACE_TIME, 32'h3);
    foreach (tbl[i])
    begin
      run(tbl[i].ctrl, tbl[i].cnt, tbl[i].trg);
      wait_idle();
      check(n_hi, tbl[i].hi);
      check(n_rise, tbl[i].rise);
      check(n_res, tbl[i].res);
      check(n_stl, tbl[i].stl);
      check(last.count, tbl[i].c);
      check(last.sum, tbl[i].sum);
      check(last.settled, tbl[i].stl != 4'h0);
      rd_chk(TQA_OFS_RESULT, tbl[i].sum[31:0]);
      rd_chk(TQA_OFS_RESULT_HI, {23'h0, tbl[i].c, tbl[i].sum[35:32]});
    end
    // Short dip and a dip inside hysteresis must not arm the trigger
    apb(1'b1, TQA_OFS_DROPOUT, 32'h6);
    run(8'h00, 5'h01, 16'h0001);
    lvl_sel <= 2'h0;
    repeat (3) @(posedge pclk);
    lvl_sel <= 2'h2;
    repeat (12) @(posedge pclk);
    lvl_sel <= 2'h1;
    repeat (12) @(posedge pclk);
    lvl_sel <= 2'h2;
    repeat (12) @(posedge pclk);
    check(n_rise, 0);
    lvl_sel <= 2'h0;
    repeat (12) @(posedge pclk);
    lvl_sel <= 2'h2;
    wait_idle();
    check(n_rise, 1);
    apb(1'b1, TQA_OFS_HOLDOFF, 32'h28);
    run(8'h15, 5'h02, 16'h0002);
    wait_idle();
    check(n_rise, 2);
    check((t_last - t_first >= 40) && (t_last - t_first <= 44), 1'b1);
    // Abort ends an unlimited continuous run before any result
    run(8'h15, 5'h02, 16'h0000);
    apb(1'b1, TQA_OFS_CMD, 32'h2);
    wait_idle();
    check(n_res, 0);
    stop_test();
  end
endmodule // tqa_sequencer_tb
`default_nettype wire
